// *** addr_map_monitor.sv ***
`timescale 1ns/1ps
`include "memmap_defs.svh"
module addr_map_monitor
   import memmap_pkg::*;
#(parameter bit LARGE = 1'b1) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic fetch_next,
   input wire logic irq_take,
   input wire logic [12:0] jump_target,
   input wire logic jump,
   input wire logic [12:0] fetch_addr,
   input wire memmap_pkg::data_req_s data_req,
   input wire logic [7:0] rdata,
   input wire logic [7:0] core_status,
   input wire logic [7:0] indirect_pointer,
   input wire logic [7:0] pc_high_latch,
   input wire logic [1:0] bank_sel
);
   // --
   // fetch and data port checks
   // --
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire logic [12:0] m = LARGE ? `LARGE_PC_MASK : `SMALL_PC_MASK;
   wire logic [7:0] d = data_req.wdata;
   wire logic [1:0] ds = data_req.wdata[6:5];
   wire logic [6:0] o = data_req.offset;
   wire logic rd = data_req.valid && !data_req.write;
   wire logic wr = data_req.valid && data_req.write;
   // pc writes through the low byte override jump and step, but an interrupt still wins
   wire logic pw = wr && (o == 7'h02 || o == 7'h00);
   reset_vec_a:
   assert property ($rose(nrst) |-> fetch_addr == 13'h0) else $error("rst pc");
   irq_vec_a:
   assert property (irq_take |=> fetch_addr == 13'h4) else $error("irq pc");
   fetch_step_a:
   assert property (fetch_next && !irq_take && !jump && !pw |=>
      fetch_addr == (($past(fetch_addr) + 13'h1) & m)) else $error("step");
   jump_load_a:
   assert property (jump && !irq_take && !pw |=>
      fetch_addr == ($past(jump_target) & m)) else $error("jump");
   bank_write_a:
   assert property (wr && o == 7'h03 |=> bank_sel == $past(ds))
   else $error("bank");
   pointer_write_a:
   assert property (wr && o == 7'h04 |=> indirect_pointer == $past(d))
   else $error("pointer");
   latch_write_a:
   assert property (wr && o == 7'h0a |=> pc_high_latch == ($past(d) & 8'h1f))
   else $error("latch");
   status_read_a:
   assert property (rd && o == 7'h03 |=> rdata == $past(core_status))
   else $error("status");
   unimp_read_a:
   assert property (rd && o == 7'h01 |=> rdata == 8'h00) else $error("unimp");
endmodule : addr_map_monitor
bind banked_memory_address_map addr_map_monitor #(.LARGE(LARGE)) i_mon (.*);

// *** banked_memory_address_map.sv ***
`timescale 1ns/1ps
`include "memmap_defs.svh"
// Behaviour
// - fetch addresses are 13 bits and instruction words 14 bits.
// - the small variant spans 4k words and wraps higher addresses.
// - the large variant spans 8k words from 0000h to 1fffh.
// - fetch starts at 0000h after reset, interrupts go to 0004h.
// - status bits 6:5 select data bank 0 to 3.
// - each bank covers direct offsets 00h to 7fh.
// - low offsets are special registers, higher ones general ram.
// - core registers respond identically in all four banks.
// - general ram holds 176 bytes small or 336 bytes large.
// - every register is reachable directly or through the pointer.
// - offset 00h of each bank accesses the pointer's target.
// - unimplemented locations read zero and ignore writes.

module banked_memory_address_map
   import memmap_pkg::*;
#(
   parameter bit LARGE = 1'b1
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic fetch_next,
   input wire logic irq_take,
   input wire logic [`PC_W-1:0] jump_target,
   input wire logic jump,
   output logic [`PC_W-1:0] fetch_addr,
   input wire memmap_pkg::data_req_s data_req,
   output logic [7:0] rdata,
   output logic [7:0] core_status,
   output logic [7:0] indirect_pointer,
   output logic [7:0] pc_high_latch,
   output logic [7:0] interrupt_control,
   output logic [1:0] bank_sel
);
   import memmap_pkg::*;

   // ------------------------------------------------------------
   // sizes of this variant
   // ------------------------------------------------------------
   localparam logic [`PC_W-1:0] PC_MASK =
      LARGE ? `LARGE_PC_MASK : `SMALL_PC_MASK;
   localparam logic [8:0] RAM_DEPTH = LARGE ? `LARGE_RAM : `SMALL_RAM;

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // one core register offset, seen alike in every bank
   function automatic logic core_hit(
      input logic [6:0] o,
      input logic [6:0] r
   );
      core_hit = (o == r);
   endfunction : core_hit

   // keep a fetch address inside the implemented space
   function automatic logic [`PC_W-1:0] wrap_pc(
      input logic [`PC_W-1:0] a
   );
      wrap_pc = a & PC_MASK;
   endfunction : wrap_pc

   // ------------------------------------------------------------
   // program counter
   // ------------------------------------------------------------
   logic [`PC_W-1:0] pc;
   logic [`PC_W-1:0] next_pc;
   logic [`PC_W-1:0] pc_plus_one;
   logic [`PC_W-1:0] pc_from_latch;
   logic pcl_write;

   assign pc_plus_one = `PC_W'(pc + `PC_W'(1));
   assign pc_from_latch = {pc_high_latch[`LATCH_W-1:0], data_req.wdata};

   // interrupt first, then a computed jump, then branch, then step
   always_comb begin
      next_pc = pc;
      if (irq_take) begin
         next_pc = `INT_VECTOR;
      end else if (pcl_write) begin
         next_pc = pc_from_latch;
      end else if (jump) begin
         next_pc = jump_target;
      end else if (fetch_next) begin
         next_pc = pc_plus_one;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pc <= `RESET_VECTOR;
      end else begin
         pc <= wrap_pc(next_pc);
      end
   end

   assign fetch_addr = pc;

   // ------------------------------------------------------------
   // bank select and address resolution
   // ------------------------------------------------------------
   logic [8:0] direct_addr;
   logic [8:0] pointer_addr;
   logic [8:0] eff_addr;
   logic [6:0] eff_ofs;
   logic is_indirect;
   logic indirect_loop;
   ram_loc_s loc;

   assign bank_sel = core_status[`BANK_MSB:`BANK_LSB];
   assign direct_addr = {bank_sel, data_req.offset};
   assign pointer_addr = {core_status[`IRP_BIT], indirect_pointer};
   assign is_indirect = (data_req.offset == `OFS_INDIRECT);

   always_comb begin
      eff_addr = direct_addr;
      if (is_indirect) begin
         eff_addr = pointer_addr;
      end
   end

   assign eff_ofs = eff_addr[6:0];
   // pointer aimed at the indirect slot itself reaches nothing
   assign indirect_loop = is_indirect && (eff_ofs == `OFS_INDIRECT);

   ram_decode #(
      .LARGE(LARGE)
   ) u_ram_decode (
      .addr(eff_addr),
      .loc(loc)
   );

   // ------------------------------------------------------------
   // core register selects, mirrored in all banks
   // ------------------------------------------------------------
   logic wr;
   logic rd;
   logic sel_pcl;
   logic sel_status;
   logic sel_pointer;
   logic sel_latch;
   logic sel_interrupt_control;
   logic sel_core;

   assign wr = data_req.valid && data_req.write;
   assign rd = data_req.valid && !data_req.write;

   assign sel_pcl = core_hit(eff_ofs, `OFS_PCL);
   assign sel_status = core_hit(eff_ofs, `OFS_STATUS);
   assign sel_pointer = core_hit(eff_ofs, `OFS_FSR);
   assign sel_latch = core_hit(eff_ofs, `OFS_PC_HIGH_LATCH);
   assign sel_interrupt_control = core_hit(eff_ofs, `OFS_INTERRUPT_CONTROL);
   assign sel_core = sel_pcl || sel_status || sel_pointer || sel_latch
      || sel_interrupt_control;

   // ------------------------------------------------------------
   // general ram
   // ------------------------------------------------------------
   logic [7:0] ram [0:`LARGE_RAM-1];
   logic ram_ok;
   logic [7:0] ram_rdata;

   // the small variant leaves the upper indices unused
   assign ram_ok = loc.hit && (loc.index < RAM_DEPTH);
   assign ram_rdata = ram[loc.index];

   // ------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------
   logic we_status;
   logic we_pointer;
   logic we_latch;
   logic we_interrupt_control;
   logic we_ram;

   assign pcl_write = wr && sel_pcl;
   assign we_status = wr && sel_status;
   assign we_pointer = wr && sel_pointer;
   assign we_latch = wr && sel_latch;
   assign we_interrupt_control = wr && sel_interrupt_control;
   assign we_ram = wr && ram_ok && !indirect_loop;

   always_ff @(posedge sys_clk) begin
      if (we_ram) begin
         ram[loc.index] <= data_req.wdata;
      end
   end

   // ------------------------------------------------------------
   // core register next values
   // ------------------------------------------------------------
   logic [7:0] next_status;
   logic [7:0] next_pointer;
   logic [7:0] next_latch;
   logic [7:0] next_interrupt_control;

   // bits 4:3 of status belong to the core, not to data writes
   always_comb begin
      next_status = core_status;
      if (we_status) begin
         next_status = (data_req.wdata & `STATUS_WR_MASK)
            | (core_status & ~(`STATUS_WR_MASK));
      end
   end

   always_comb begin
      next_pointer = indirect_pointer;
      if (we_pointer) begin
         next_pointer = data_req.wdata;
      end
   end

   // only the bits that reach the large variant's program counter are kept
   always_comb begin
      next_latch = pc_high_latch;
      if (we_latch) begin
         next_latch = data_req.wdata & `LATCH_MASK;
      end
   end

   always_comb begin
      next_interrupt_control = interrupt_control;
      if (we_interrupt_control) begin
         next_interrupt_control = data_req.wdata;
      end
   end

   // ------------------------------------------------------------
   // core registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         core_status <= `STATUS_RST;
      end else begin
         core_status <= next_status;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         indirect_pointer <= 8'h00;
      end else begin
         indirect_pointer <= next_pointer;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pc_high_latch <= 8'h00;
      end else begin
         pc_high_latch <= next_latch;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         interrupt_control <= 8'h00;
      end else begin
         interrupt_control <= next_interrupt_control;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [7:0] core_rdata;
   logic [7:0] next_rdata;

   always_comb begin
      core_rdata = 8'h00;
      case (1'b1)
         sel_pcl: core_rdata = pc[7:0];
         sel_status: core_rdata = core_status;
         sel_pointer: core_rdata = indirect_pointer;
         sel_latch: core_rdata = pc_high_latch;
         sel_interrupt_control: core_rdata = interrupt_control;
         default: core_rdata = 8'h00;
      endcase
   end

   // anything neither core register nor ram reads as zero
   always_comb begin
      next_rdata = 8'h00;
      if (indirect_loop) begin
         next_rdata = 8'h00;
      end else if (sel_core) begin
         next_rdata = core_rdata;
      end else if (ram_ok) begin
         next_rdata = ram_rdata;
      end
   end

   // holds until the next read request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= next_rdata;
      end
   end
endmodule : banked_memory_address_map

// *** core_model.sv ***
`timescale 1ns/1ps
module core_model
   import memmap_pkg::*;
(
   input wire logic sys_clk,
   output memmap_pkg::data_req_s data_req = '0,
   output logic fetch_next = 1'b0,
   output logic irq_take = 1'b0,
   output logic jump = 1'b0,
   output logic [12:0] jump_target = 13'h0
);
   // --
   // one request, then release with lines inverted
   // --
   task acc(input logic w, input logic [6:0] o, input logic [7:0] d);
      data_req <= '{1'b1, w, o, d};
      @(posedge sys_clk);
      data_req <= '{1'b0, 1'b0, ~o, ~d};
      @(posedge sys_clk);
   endtask : acc
   task pc(input logic [2:0] c, input logic [12:0] t);
      {fetch_next, irq_take, jump} <= c;
      jump_target <= t;
      @(posedge sys_clk);
      {fetch_next, irq_take, jump} <= 3'h0;
      jump_target <= ~t;
      @(posedge sys_clk);
   endtask : pc
endmodule : core_model

// *** memmap_defs.svh ***
`ifndef MEMMAP_DEFS_SVH
`define MEMMAP_DEFS_SVH

`define PC_W 13
`define INSN_W 14
`define SMALL_PC_MASK 13'h0fff
`define LARGE_PC_MASK 13'h1fff
`define RESET_VECTOR 13'h0000
`define INT_VECTOR 13'h0004
`define OFS_INDIRECT 7'h00
`define OFS_PCL 7'h02
`define OFS_STATUS 7'h03
`define OFS_FSR 7'h04
`define OFS_PC_HIGH_LATCH 7'h0a
`define OFS_INTERRUPT_CONTROL 7'h0b
`define BANK_MSB 6
`define BANK_LSB 5
`define GPR0_LO 7'h20
`define GPR12_LO 7'h20
`define GPR12_HI 7'h6f
`define COMMON_LO 7'h70
`define BANK0_SIZE 9'h060
`define BANK12_SIZE 9'h050
`define RAM_B1_BASE 9'h060
`define RAM_B2_BASE 9'h0b0
`define RAM_B3_BASE 9'h100
`define SMALL_RAM 9'h100
`define LARGE_RAM 9'h160
`define STATUS_RST 8'h18
`define STATUS_WR_MASK 8'he7
`define LATCH_MASK 8'h1f
`define LATCH_W 5
`define IRP_BIT 7

`endif

// *** memmap_pkg.sv ***
package memmap_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] offset;
      logic [7:0] wdata;
   } data_req_s;

   typedef struct packed {
      logic hit;
      logic [8:0] index;
   } ram_loc_s;
endpackage : memmap_pkg

// *** ram_decode.sv ***
`timescale 1ns/1ps
`include "memmap_defs.svh"

module ram_decode
   import memmap_pkg::*;
#(
   parameter bit LARGE = 1'b1
) (
   input wire logic [8:0] addr,
   output memmap_pkg::ram_loc_s loc
);
   import memmap_pkg::*;

   logic [6:0] ofs;
   logic [1:0] bank;

   assign ofs = addr[6:0];
   assign bank = addr[8:7];

   always_comb begin
      loc.hit = 1'b0;
      loc.index = 9'h000;
      if (ofs >= `COMMON_LO) begin
         loc.hit = 1'b1;
         loc.index = 9'({2'b00, ofs} - {2'b00, `GPR0_LO});
      end else if (ofs >= `GPR12_LO) begin
         case (bank)
            2'h0: begin
               loc.hit = 1'b1;
               loc.index = 9'({2'b00, ofs} - {2'b00, `GPR0_LO});
            end
            2'h1: begin
               loc.hit = 1'b1;
               loc.index = 9'({2'b00, ofs} - {2'b00, `GPR12_LO}
                  + `RAM_B1_BASE);
            end
            2'h2: begin
               loc.hit = LARGE;
               loc.index = 9'({2'b00, ofs} - {2'b00, `GPR12_LO}
                  + `RAM_B2_BASE);
            end
            2'h3: begin
               loc.hit = LARGE && (ofs <= `GPR12_HI);
               loc.index = 9'({2'b00, ofs} - {2'b00, `GPR12_LO}
                  + `RAM_B3_BASE);
            end
            default: begin
               loc.hit = 1'b0;
            end
         endcase
      end
   end
endmodule : ram_decode

// *** tb_banked_memory_address_map.sv ***
`timescale 1ns/1ps
module tb_banked_memory_address_map;
   import memmap_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic rd_d = 1'b0;
   data_req_s data_req;
   logic fetch_next, irq_take, jump;
   logic [12:0] jump_target, fetch_addr, fetch_addr_s;
   logic [7:0] rdata, core_status, indirect_pointer, pc_high_latch, a, b;
   logic [7:0] interrupt_control;
   logic [1:0] bank_sel;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int tests_run = 0;
   // --
   // clock, core model, device and result watcher
   // --
   always #4 sys_clk = ~sys_clk;
   core_model cm (.*);
   banked_memory_address_map i_banked_memory_address_map (.*);
   banked_memory_address_map #(
      .LARGE(1'b0)
   ) i_banked_memory_address_map_small (.*, .fetch_addr(fetch_addr_s),
      .rdata(), .core_status(), .indirect_pointer(), .pc_high_latch(),
      .interrupt_control(), .bank_sel());
   task chk_rdata(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value rdata expected %h seen %h", e, g);
      end
   endtask : chk_rdata
   task chk_pc(input string n, input logic [12:0] e, input logic [12:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk_pc
   task chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg
   always @(posedge sys_clk) rd_d <= data_req.valid && !data_req.write;
   always @(negedge sys_clk) if (rd_d)
      chk_rdata(exp_q.pop_front(), rdata);
   task pcq(input logic [12:0] e, input logic [12:0] es);
      @(negedge sys_clk);
      chk_pc("fetch_addr", e, fetch_addr);
      chk_pc("fetch_addr_small", es, fetch_addr_s);
      @(posedge sys_clk);
   endtask : pcq
   task rd(input logic [6:0] o, input logic [7:0] e);
      exp_q.push_back(e);
      cm.acc(1'b0, o, 8'h00);
   endtask : rd
   task wr(input logic [6:0] o, input logic [7:0] d);
      cm.acc(1'b1, o, d);
   endtask : wr
   task conclude;
      if (exp_q.size() != 0) n_fail++;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end
   initial begin
      void'($urandom(46391));
      a = 8'($urandom);
      b = 8'($urandom);
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      pcq(13'h0, 13'h0);
      rd(7'h03, 8'h18);
      repeat (3) cm.pc(3'b100, 13'h0);
      pcq(13'h3, 13'h3);
      cm.pc(3'b111, 13'h0);
      pcq(13'h4, 13'h4);
      cm.pc(3'b001, 13'h1fff);
      pcq(13'h1fff, 13'h0fff);
      cm.pc(3'b100, 13'h0);
      pcq(13'h0, 13'h0);
      $display("test fetch done");
      wr(7'h04, a);
      for (int k = 0; k < 4; k++) begin
         wr(7'h03, {1'b0, 2'(k), 5'h0});
         rd(7'h04, a);
         wr(7'h01, a);
         rd(7'h01, 8'h00);
         wr(7'h20, a ^ 8'(k));
         wr(7'h70, b ^ 8'(k));
      end
      for (int k = 0; k < 4; k++) begin
         wr(7'h03, {1'b0, 2'(k), 5'h0});
         rd(7'h20, a ^ 8'(k));
         rd(7'h70, b ^ 8'h03);
      end
      $display("test banks done");
      wr(7'h04, 8'h20);
      wr(7'h00, b);
      wr(7'h03, 8'h00);
      rd(7'h20, b);
      wr(7'h04, 8'h80);
      rd(7'h00, 8'h00);
      wr(7'h03, 8'h60);
      wr(7'h0b, b);
      @(negedge sys_clk);
      chk_reg("interrupt_control", b, interrupt_control);
      @(posedge sys_clk);
      rd(7'h0b, b);
      wr(7'h0a, a);
      rd(7'h0a, {3'h0, a[4:0]});
      wr(7'h02, b);
      pcq({a[4:0], b}, {1'b0, a[3:0], b});
      $display("test indirect done");
      conclude();
   end
endmodule : tb_banked_memory_address_map
